// [src/ref_clock_pkg.sv]
// constants, types and decode helpers for the reference clock output generator
// Operation
// R01 - Generator input picks logic cells, numeric oscillator, oscillators or system clock.
// R02 - Generated clock drives the output pin and the internal peripheral consumers.
// R03 - Setting the enable starts the output cleanly, with no glitch or runt.
// R04 - Clearing the enable stops the output at once, mid-period if need be.
// R05 - Divider and duty changes are accepted while enabled; software should avoid it.
// R06 - Selected input is divided by 1, 2, 4, 8, 16, 32, 64 or 128.
// R07 - Divided modes give 0%, 25%, 50% or 75% duty per duty select.
// R08 - Undivided mode gives 50% for nonzero duty; duty zero holds output low.
// R09 - Reset loads duty select with the 50% code.
// R10 - In sleep the output keeps running except with the system clock source.
// R11 - Divide code 000 passes undivided; code n divides by two to the n.
// R12 - Duty code 11 is 75%, 10 is 50%, 01 is 25%, 00 is 0%.
// R13 - Source 0000 system clock, 0001-0110 oscillators, 0111-1010 cells, rest reserved.
// R14 - Reset clears the module enable so the output stays inactive.
// R15 - While disabled, output low and counters held at their start state.
// R16 - Reserved source codes select no clock and hold the output low.
package ref_clock_pkg;

	// ----------------------------------------------------------------
	// control register layout
	// ----------------------------------------------------------------
	localparam int EN_BIT = 7;
	localparam int DUTY_LSB = 3;
	localparam int DIV_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h10;
	localparam logic [7:0] CTRL_MASK = 8'h9F;
	localparam logic [3:0] SRC_RESET = 4'h0;

	// ----------------------------------------------------------------
	// source codes and field values
	// ----------------------------------------------------------------
	localparam int NUM_SOURCES = 11;
	localparam logic [3:0] SRC_SYSTEM = 4'h0;
	localparam logic [3:0] SRC_LAST = 4'hA;
	localparam logic [1:0] DUTY_ZERO = 2'h0;
	localparam logic [2:0] DIV_NONE = 3'h0;

	typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} gen_state_t;

	// half-period counter wraps at twice the divide ratio
	function automatic logic [7:0] half_mask(input logic [2:0] div);
		logic [8:0] span;
		span = 9'h002 << div;
		return 8'(span - 9'h001);
	endfunction

	// half-periods spent high: duty quarters times half the ratio
	function automatic logic [8:0] high_limit(input logic [2:0] div, input logic [1:0] duty);
		logic [8:0] base;
		base = {7'h00, duty};
		return (div == DIV_NONE) ? 9'h000 : (base << (div - 3'h1));
	endfunction

endpackage

// [src/clock_sync.sv]
// two-stage synchroniser for asynchronous clock source levels
`timescale 1ns/1ps
module clock_sync #(
	parameter int WIDTH = 11
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] held;
	} sync_state_t;

	sync_state_t st_q;
	sync_state_t st_d;

	// first stage is read only by the second stage
	always_comb begin
		st_d.meta = async_in;
		st_d.held = st_q.meta;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.held;

endmodule

// [src/reference_clock_module.sv]
// reference clock output generator: source mux, power-of-two divider, duty shaping
`timescale 1ns/1ps
module reference_clock_module
	import ref_clock_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [NUM_SOURCES-1:0] clock_sources,
	input wire logic sleep_mode,
	input wire logic control_write,
	input wire logic [7:0] control_wdata,
	input wire logic source_write,
	input wire logic [3:0] source_wdata,
	output logic [7:0] control_rdata,
	output logic [3:0] source_rdata,
	output logic ref_clock_out_pin,
	output logic ref_clock_internal
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		gen_state_t fsm;
		logic [7:0] cnt;
		logic prev;
		logic out_pin;
		logic out_int;
		logic [7:0] ref_generator_control_reg;
		logic [3:0] ref_generator_source_reg;
	} state_t;

	localparam state_t STATE_RESET = '{
		fsm: S_IDLE,
		cnt: 8'h00,
		prev: 1'b0,
		out_pin: 1'b0,
		out_int: 1'b0,
		ref_generator_control_reg: CTRL_RESET,
		ref_generator_source_reg: SRC_RESET
	};

	state_t st_q;
	state_t st_d;
	logic [NUM_SOURCES-1:0] src_s;
	logic sel_lvl;
	logic src_rise;
	logic src_edge;
	logic active;
	logic out_nxt;
	logic [2:0] div_sel;
	logic [1:0] duty_select;

	// sources come from foreign clocks; they must be slower than ref_clk/2
	// since edges are found by sampling, a limitation of the single-clock build
	clock_sync #(
		.WIDTH(NUM_SOURCES)
	) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.async_in(clock_sources),
		.sync_out(src_s)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		div_sel = st_q.ref_generator_control_reg[DIV_LSB +: 3];
		duty_select = st_q.ref_generator_control_reg[DUTY_LSB +: 2];
		// settings taken even while running; glitches are software's problem
		if (control_write) begin
			st_d.ref_generator_control_reg = control_wdata & CTRL_MASK; // R05
		end
		if (source_write) begin
			st_d.ref_generator_source_reg = source_wdata;
		end
		// reserved codes select no clock
		if (st_q.ref_generator_source_reg <= SRC_LAST) begin
			sel_lvl = src_s[st_q.ref_generator_source_reg]; // R01 R13
		end else begin
			sel_lvl = 1'b0; // R16
		end
		st_d.prev = sel_lvl;
		src_rise = sel_lvl & ~st_q.prev;
		src_edge = sel_lvl ^ st_q.prev;
		active = st_q.ref_generator_control_reg[EN_BIT]
			&& !(sleep_mode && st_q.ref_generator_source_reg == SRC_SYSTEM) // R10
			&& (st_q.ref_generator_source_reg <= SRC_LAST); // R16
		out_nxt = 1'b0;
		if (!active) begin
			st_d.fsm = S_IDLE; // R04
			st_d.cnt = 8'h00; // R15
		end else begin
			case (st_q.fsm)
				S_IDLE: begin
					st_d.fsm = S_ARMED;
				end
				S_ARMED: begin
					// wait for a fresh rising edge so the first pulse is whole
					if (src_rise) begin
						st_d.fsm = S_RUN; // R03
						st_d.cnt = 8'h00;
					end
				end
				S_RUN: begin
					if (src_edge) begin
						st_d.cnt = (st_q.cnt + 8'h01) & half_mask(div_sel); // R06 R11
					end
				end
				default: begin
					st_d.fsm = S_IDLE;
				end
			endcase
		end
		if (st_d.fsm == S_RUN) begin
			if (div_sel == DIV_NONE) begin
				out_nxt = (duty_select != DUTY_ZERO) && sel_lvl; // R08
			end else begin
				out_nxt = {1'b0, st_d.cnt} < high_limit(div_sel, duty_select); // R07 R12
			end
		end
		st_d.out_pin = out_nxt; // R02
		st_d.out_int = out_nxt; // R02
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= STATE_RESET; // R09 R14
		end else begin
			st_q <= st_d;
		end
	end

	assign control_rdata = st_q.ref_generator_control_reg;
	assign source_rdata = st_q.ref_generator_source_reg;
	assign ref_clock_out_pin = st_q.out_pin;
	assign ref_clock_internal = st_q.out_int;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	dis_low_a: assert property (!st_q.ref_generator_control_reg[EN_BIT] |=> !ref_clock_out_pin) // R04
		else $error("output not low after disable");
	reserved_low_a: assert property (st_q.ref_generator_source_reg > SRC_LAST |=> !ref_clock_out_pin) // R16
		else $error("output active on reserved source");
	sleep_stop_a: assert property (sleep_mode && st_q.ref_generator_source_reg == SRC_SYSTEM
		|=> !ref_clock_out_pin) // R10
		else $error("output active in sleep on system clock");
	duty_zero_a: assert property (duty_select == DUTY_ZERO && !control_write |=> !ref_clock_out_pin) // R08
		else $error("output high with zero duty");
	pins_match_a: assert property (ref_clock_out_pin == ref_clock_internal) // R02
		else $error("pin and internal copies differ");
	clean_start_a: assert property ($rose(ref_clock_out_pin) |-> $past(src_rise)
		|| ($past(st_q.fsm) == S_RUN && $past(div_sel) != DIV_NONE)) // R03
		else $error("output rose outside a running edge");
	idle_count_a: assert property (!active |=> st_q.cnt == 8'h00 && st_q.fsm == S_IDLE) // R15
		else $error("counter not held while disabled");
	// checked on the step itself: a divider change while running may leave a stale count
	count_wrap_a: assert property (st_q.fsm == S_RUN && active && src_edge
		|=> st_q.cnt <= half_mask($past(div_sel))) // R06
		else $error("divider count past its wrap");
	ctrl_write_a: assert property (control_write |=> control_rdata == $past(control_wdata & CTRL_MASK)) // R05
		else $error("control write not stored");

	run_slow_c: cover property (st_q.fsm == S_RUN && div_sel == 3'h7 && $rose(ref_clock_out_pin));
	run_wide_c: cover property (duty_select == 2'h3 && div_sel == 3'h1 && $fell(ref_clock_out_pin));
	sleep_run_c: cover property (sleep_mode && st_q.ref_generator_source_reg == 4'h3
		&& $rose(ref_clock_out_pin));

endmodule

// [tb/src_model.sv]
// clock source model: eleven free-running levels of distinct rates
`timescale 1ns/1ps
module src_model (
	input wire logic ref_clk,
	output logic [10:0] clock_sources
);
	int cnt [11];
	initial begin
		clock_sources = 11'h000;
		foreach (cnt[i]) cnt[i] = 0;
	end
	// level i held 3+i cycles: distinct rates expose a wrong mux pick
	always @(negedge ref_clk) begin
		for (int i = 0; i < 11; i++) begin
			if (cnt[i] == 2 + i) begin
				cnt[i] <= 0;
				clock_sources[i] <= ~clock_sources[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the reference clock output generator
`timescale 1ns/1ps
module tb_top;
	import ref_clock_pkg::*;
	logic ref_clk, nrst, sleep_mode, control_write, source_write, pin, internal;
	logic [7:0] control_wdata, control_rdata;
	logic [3:0] source_wdata, source_rdata;
	logic [NUM_SOURCES-1:0] clock_sources;
	logic [15:0] hi;
	int fails, checked, s, p;
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	src_model u_src_model (.ref_clk(ref_clk), .clock_sources(clock_sources));
	reference_clock_module u_reference_clock_module (
		.ref_clk(ref_clk), .nrst(nrst), .clock_sources(clock_sources),
		.sleep_mode(sleep_mode), .control_write(control_write),
		.control_wdata(control_wdata), .source_write(source_write),
		.source_wdata(source_wdata), .control_rdata(control_rdata),
		.source_rdata(source_rdata), .ref_clock_out_pin(pin),
		.ref_clock_internal(internal));
	// ----------------------------------------------------------------
	// access and measurement tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// both registers in one strobe cycle, which the block accepts
	task automatic wr(input logic [7:0] c, input logic [3:0] src);
		control_write = 1'b1;
		control_wdata = c;
		source_write = 1'b1;
		source_wdata = src;
		@(negedge ref_clk);
		control_write = 1'b0;
		source_write = 1'b0;
		@(negedge ref_clk);
	endtask
	// high cycles on the pin; any pin/internal difference is added on top
	task automatic measure(input int n, output logic [15:0] h);
		h = 16'h0000;
		repeat (n) begin
			@(negedge ref_clk);
			h = h + 16'(pin) + 16'(pin !== internal) * 16'h1000;
		end
	endtask
	task automatic complete_run;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#1000000;
		fails++;
		complete_run();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		fails = 0;
		checked = 0;
		{nrst, sleep_mode, control_write, source_write} = 4'h0;
		control_wdata = 8'h00;
		source_wdata = 4'h0;
		repeat (3) @(negedge ref_clk);
		check({control_rdata, source_rdata, 2'h0, internal, pin}, 16'h1000);
		nrst = 1'b1;
		wr(8'hFF, 4'h0);
		check({8'h00, control_rdata}, 16'h009F);
		wr(8'h00, 4'h0);
		check({15'h0000, pin}, 16'h0000);
		for (int d = 0; d < 8; d++) begin
			for (int c = 0; c < 4; c++) begin
				s = (d * 4 + c) % 11;
				p = (6 + 2 * s) << d;
				wr({1'b1, 4'(c), 3'(d)}, 4'(s));
				check({12'h000, source_rdata}, 16'(s));
				measure(p + 16, hi);
				measure(2 * p, hi);
				check(hi, 16'((d == 0) ? ((c != 0) ? p : 0) : p * c / 2));
				wr(8'h00, 4'(s));
			end
		end
		// reset while running must drop the enable and restore the duty code
		wr(8'h9B, 4'h2);
		measure(32, hi);
		nrst = 1'b0;
		@(negedge ref_clk);
		check({control_rdata, source_rdata, 2'h0, internal, pin}, 16'h1000);
		nrst = 1'b1;
		measure(24, hi);
		check(hi, 16'h0000);
		sleep_mode = 1'b1;
		wr(8'h91, 4'h0);
		measure(64, hi);
		check(hi, 16'h0000);
		wr(8'h11, 4'h3);
		wr(8'h91, 4'h3);
		measure(40, hi);
		measure(48, hi);
		check(hi, 16'h0018);
		sleep_mode = 1'b0;
		wr(8'h11, 4'hB);
		wr(8'h91, 4'hB);
		measure(64, hi);
		check(hi, 16'h0000);
		complete_run();
	end
endmodule
